// [hdl/periph_reset_pkg.sv]
// Constants for the peripheral software reset control block.
// Assumes a single system clock and a plain register port with 32-bit data.
`default_nettype none

package periph_reset_pkg;

  // ==========================================================================
  // Bus geometry
  localparam int ADDR_WIDTH = 12;
  localparam int DATA_WIDTH = 32;

  // ==========================================================================
  // Register offsets
  localparam logic [11:0] PERIPH_RESET_CTRL_A_OFFSET = 12'h040;
  localparam logic [11:0] PERIPH_RESET_CTRL_B_OFFSET = 12'h044;

  // ==========================================================================
  // Reset values
  localparam logic [31:0] PERIPH_RESET_CTRL_A_RESET = 32'h0000_0000;
  localparam logic [31:0] PERIPH_RESET_CTRL_B_RESET = 32'h0000_0000;
  localparam logic [31:0] READ_IDLE_VALUE = 32'h0000_0000;

  // ==========================================================================
  // Field positions, first register
  localparam int PWM_RESET_BIT = 20;
  localparam int ADC_ZERO_RESET_BIT = 16;
  localparam int SLEEP_UNIT_RESET_BIT = 6;
  localparam int WATCHDOG_RESET_BIT = 3;

  // ==========================================================================
  // Field positions, second register
  localparam int ANALOG_CMP_LSB = 24;
  localparam int ANALOG_CMP_COUNT = 3;
  localparam int GP_COUNTER_LSB = 16;
  localparam int GP_COUNTER_COUNT = 4;
  localparam int TWO_WIRE_ONE_RESET_BIT = 14;
  localparam int TWO_WIRE_ZERO_RESET_BIT = 12;
  localparam int QUAD_ENCODER_LSB = 8;
  localparam int QUAD_ENCODER_COUNT = 2;
  localparam int SYNC_SERIAL_LSB = 4;
  localparam int SYNC_SERIAL_COUNT = 2;
  localparam int ASYNC_SERIAL_LSB = 0;
  localparam int ASYNC_SERIAL_COUNT = 3;

  // ==========================================================================
  // Implemented (writable) bits; all others are reserved and read zero
  localparam logic [31:0] PERIPH_RESET_CTRL_A_WRITABLE = 32'h0011_0048;
  localparam logic [31:0] PERIPH_RESET_CTRL_B_WRITABLE = 32'h070f_5337;

endpackage

`default_nettype wire

// [hdl/masked_reset_word.sv]
// One software reset word with per-bit write masking.
// Assumes capability bits come from logic on the same clock.
`default_nettype none

module masked_reset_word #(
  parameter int WIDTH = 32,
  parameter logic [31:0] WRITABLE = 32'h0000_0000,
  parameter logic [31:0] RESET_VALUE = 32'h0000_0000
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic write_hit,
  input wire logic [WIDTH-1:0] write_data,
  input wire logic [WIDTH-1:0] capability,
  output logic [WIDTH-1:0] value
);

  if (WIDTH < 1 || WIDTH > 32)
  begin : g_bad_width
    $error("masked_reset_word: WIDTH must be 1 to 32");
  end

  // ==========================================================================
  // Per-bit storage
  for (genvar i = 0; i < WIDTH; i++)
  begin : g_bit
    if (WRITABLE[i])
    begin : g_live
      logic held;
      wire bit_write = write_hit & capability[i];
      always_ff @(posedge clock)
      begin
        if (sys_rst)
          held <= RESET_VALUE[i];
        else if (bit_write)
          held <= write_data[i];
      end
      assign value[i] = held;
    end
    else
    begin : g_reserved
      assign value[i] = 1'b0;
    end
  end

endmodule

`default_nettype wire

// [hdl/reset_read_port.sv]
// Registered read data path for the two reset words.
// Assumes read strobes are single cycles; data stands one cycle only.
`default_nettype none

module reset_read_port (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic read_strobe,
  input wire logic hit_a,
  input wire logic hit_b,
  input wire logic [31:0] word_a,
  input wire logic [31:0] word_b,
  output logic [31:0] read_data
);

  // ==========================================================================
  // Selection
  wire [31:0] selected = hit_a ? word_a :
                         hit_b ? word_b :
                         periph_reset_pkg::READ_IDLE_VALUE;
  wire [31:0] next_read_data = read_strobe ? selected : periph_reset_pkg::READ_IDLE_VALUE;

  // ==========================================================================
  // Output register
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      read_data <= periph_reset_pkg::READ_IDLE_VALUE;
    else
      read_data <= next_read_data;
  end

endmodule

`default_nettype wire

// [hdl/peripheral_software_reset_ctrl.sv]
// Software reset control for the on-chip peripherals: two reset words.
// Assumes one system clock, a plain register port, and capability masks
// supplied by the capability registers on the same clock.
//
// How it works
// - A write changes a reset bit only where its capability bit is set.
// - First reset word at offset 0x040, read/write, resets to zero.
// - Second reset word at offset 0x044, read/write, resets to zero.
// - First word bit 20 resets the pulse-width modulation module.
// - First word bit 16 resets converter module 0.
// - First word bit 6 resets the hibernation module.
// - First word bit 3 resets the watchdog unit.
// - Second word bits 26..24 reset analog comparators 2..0.
// - Second word bits 19..16 reset general-purpose timers 3..0.
// - Second word bit 14 resets two-wire unit 1, bit 12 unit 0.
// - Second word bits 9 and 8 reset quadrature encoders 1 and 0.
// - Second word bits 5 and 4 reset synchronous serial units 1 and 0.
// - Second word bits 2..0 reset asynchronous serial units 2..0.
// - Unassigned bits of both words are read-only and read zero.
`default_nettype none

module peripheral_software_reset_ctrl (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [periph_reset_pkg::ADDR_WIDTH-1:0] reg_addr,
  input wire logic [periph_reset_pkg::DATA_WIDTH-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [periph_reset_pkg::DATA_WIDTH-1:0] reg_rdata,
  input wire logic [periph_reset_pkg::DATA_WIDTH-1:0] capability_mask_a,
  input wire logic [periph_reset_pkg::DATA_WIDTH-1:0] capability_mask_b,
  output logic pwm_reset,
  output logic adc_zero_reset,
  output logic sleep_unit_reset,
  output logic watchdog_reset_bit,
  output logic analog_cmp_zero_reset,
  output logic analog_cmp_one_reset,
  output logic analog_cmp_two_reset,
  output logic gp_counter_zero_reset,
  output logic gp_counter_one_reset,
  output logic gp_counter_two_reset,
  output logic gp_counter_three_reset,
  output logic two_wire_zero_reset,
  output logic two_wire_one_reset,
  output logic quad_encoder_zero_reset,
  output logic quad_encoder_one_reset,
  output logic sync_serial_zero_reset,
  output logic sync_serial_one_reset,
  output logic async_serial_zero_reset,
  output logic async_serial_one_reset,
  output logic async_serial_two_reset
);

  // ==========================================================================
  // Address decode
  wire [11:0] word_addr = reg_addr[11:0];
  wire hit_a = (word_addr == periph_reset_pkg::PERIPH_RESET_CTRL_A_OFFSET);
  wire hit_b = (word_addr == periph_reset_pkg::PERIPH_RESET_CTRL_B_OFFSET);
  wire write_a = reg_write & hit_a;
  wire write_b = reg_write & hit_b;

  // ==========================================================================
  // Reset words
  logic [31:0] periph_reset_ctrl_a;
  logic [31:0] periph_reset_ctrl_b;

  masked_reset_word #(
    .WIDTH(32),
    .WRITABLE(periph_reset_pkg::PERIPH_RESET_CTRL_A_WRITABLE),
    .RESET_VALUE(periph_reset_pkg::PERIPH_RESET_CTRL_A_RESET)
  ) u_word_a (
    .clock(clock),
    .sys_rst(sys_rst),
    .write_hit(write_a),
    .write_data(reg_wdata),
    .capability(capability_mask_a),
    .value(periph_reset_ctrl_a)
  );

  masked_reset_word #(
    .WIDTH(32),
    .WRITABLE(periph_reset_pkg::PERIPH_RESET_CTRL_B_WRITABLE),
    .RESET_VALUE(periph_reset_pkg::PERIPH_RESET_CTRL_B_RESET)
  ) u_word_b (
    .clock(clock),
    .sys_rst(sys_rst),
    .write_hit(write_b),
    .write_data(reg_wdata),
    .capability(capability_mask_b),
    .value(periph_reset_ctrl_b)
  );

  // ==========================================================================
  // Read back
  // unmapped and reserved read zero
  reset_read_port u_read (
    .clock(clock),
    .sys_rst(sys_rst),
    .read_strobe(reg_read),
    .hit_a(hit_a),
    .hit_b(hit_b),
    .word_a(periph_reset_ctrl_a),
    .word_b(periph_reset_ctrl_b),
    .read_data(reg_rdata)
  );

  // ==========================================================================
  // Reset lines, first word (bits held in flip-flops)
  // level held reset
  assign pwm_reset = periph_reset_ctrl_a[periph_reset_pkg::PWM_RESET_BIT];
  assign adc_zero_reset = periph_reset_ctrl_a[periph_reset_pkg::ADC_ZERO_RESET_BIT];
  assign sleep_unit_reset = periph_reset_ctrl_a[periph_reset_pkg::SLEEP_UNIT_RESET_BIT];
  assign watchdog_reset_bit = periph_reset_ctrl_a[periph_reset_pkg::WATCHDOG_RESET_BIT];

  // ==========================================================================
  // Reset lines, second word
  localparam int CMP = periph_reset_pkg::ANALOG_CMP_LSB;
  localparam int CNT = periph_reset_pkg::GP_COUNTER_LSB;
  localparam int QE = periph_reset_pkg::QUAD_ENCODER_LSB;
  localparam int SS = periph_reset_pkg::SYNC_SERIAL_LSB;
  localparam int AS = periph_reset_pkg::ASYNC_SERIAL_LSB;

  assign analog_cmp_zero_reset = periph_reset_ctrl_b[CMP];
  assign analog_cmp_one_reset = periph_reset_ctrl_b[CMP + 1];
  assign analog_cmp_two_reset = periph_reset_ctrl_b[CMP + 2];
  assign gp_counter_zero_reset = periph_reset_ctrl_b[CNT];
  assign gp_counter_one_reset = periph_reset_ctrl_b[CNT + 1];
  assign gp_counter_two_reset = periph_reset_ctrl_b[CNT + 2];
  assign gp_counter_three_reset = periph_reset_ctrl_b[CNT + 3];
  assign two_wire_zero_reset = periph_reset_ctrl_b[periph_reset_pkg::TWO_WIRE_ZERO_RESET_BIT];
  assign two_wire_one_reset = periph_reset_ctrl_b[periph_reset_pkg::TWO_WIRE_ONE_RESET_BIT];
  assign quad_encoder_zero_reset = periph_reset_ctrl_b[QE];
  assign quad_encoder_one_reset = periph_reset_ctrl_b[QE + 1];
  assign sync_serial_zero_reset = periph_reset_ctrl_b[SS];
  assign sync_serial_one_reset = periph_reset_ctrl_b[SS + 1];
  assign async_serial_zero_reset = periph_reset_ctrl_b[AS];
  assign async_serial_one_reset = periph_reset_ctrl_b[AS + 1];
  assign async_serial_two_reset = periph_reset_ctrl_b[AS + 2];

endmodule

`default_nettype wire

// [tb/reset_ctrl_props.sv]
// Concurrent checks on the ports of the peripheral reset block.
// Assumes binding to the top module, all ports on one clock.
`default_nettype none
module reset_ctrl_props (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [31:0] reg_rdata,
  input wire logic [31:0] capability_mask_a,
  input wire logic [31:0] capability_mask_b,
  input wire logic pwm_reset,
  input wire logic watchdog_reset_bit,
  input wire logic analog_cmp_two_reset,
  input wire logic async_serial_zero_reset
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  wire hit_a = reg_addr == 12'h040;
  wire hit_b = reg_addr == 12'h044;
  // ====================
  // Assertions
  a_mask_keeps: assert property (reg_write && hit_a && !capability_mask_a[20] |=>
    $stable(pwm_reset)) else $error("masked bit changed");
  a_pwm_write: assert property (reg_write && hit_a && capability_mask_a[20] |=>
    pwm_reset == $past(reg_wdata[20])) else $error("pwm bit not written");
  a_wdog_hold: assert property (!(reg_write && hit_a) |=>
    $stable(watchdog_reset_bit)) else $error("watchdog bit moved");
  a_cmp_hold: assert property (!(reg_write && hit_b) |=>
    $stable(analog_cmp_two_reset)) else $error("comparator bit moved");
  a_uart_write: assert property (reg_write && hit_b && capability_mask_b[0] |=>
    async_serial_zero_reset == $past(reg_wdata[0])) else $error("uart bit not written");
  a_read_first: assert property (reg_read && hit_a |=> reg_rdata[20] == $past(pwm_reset)
    && (reg_rdata & ~32'h0011_0048) == 32'h0) else $error("first word read wrong");
  a_read_second: assert property (reg_read && hit_b |=> reg_rdata[0] ==
    $past(async_serial_zero_reset) && (reg_rdata & ~32'h070f_5337) == 32'h0)
    else $error("second word read wrong");
  a_read_unmapped: assert property (reg_read && !hit_a && !hit_b |=>
    reg_rdata == 32'h0) else $error("unmapped read not zero");
  a_reset_clear: assert property ($fell(sys_rst) |-> !pwm_reset && !watchdog_reset_bit
    && !analog_cmp_two_reset && reg_rdata == 32'h0) else $error("reset left bits set");
  // ====================
  // Coverage
  c_write_a: cover property (reg_write && hit_a && capability_mask_a[20]);
  c_read_b: cover property (reg_read && hit_b);
  c_masked_b: cover property (reg_write && hit_b && !capability_mask_b[26]);
endmodule
bind peripheral_software_reset_ctrl reset_ctrl_props i_props (.*);
`default_nettype wire

// [tb/test_peripheral_software_reset_ctrl.sv]
// Self-checking bench for the peripheral reset block.
// Assumes the design package, design and checker are compiled first.
`default_nettype none
module test_peripheral_software_reset_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic [11:0] reg_addr = 12'h000;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [31:0] reg_rdata;
  logic [31:0] capability_mask_a = 32'hffff_ffff;
  logic [31:0] capability_mask_b = 32'hffff_ffff;
  logic pwm_reset, adc_zero_reset, sleep_unit_reset, watchdog_reset_bit;
  logic analog_cmp_zero_reset, analog_cmp_one_reset, analog_cmp_two_reset;
  logic gp_counter_zero_reset, gp_counter_one_reset, gp_counter_two_reset;
  logic gp_counter_three_reset, two_wire_zero_reset, two_wire_one_reset;
  logic quad_encoder_zero_reset, quad_encoder_one_reset;
  logic sync_serial_zero_reset, sync_serial_one_reset;
  logic async_serial_zero_reset, async_serial_one_reset, async_serial_two_reset;
  logic [31:0] model_a = 32'h0;
  logic [31:0] model_b = 32'h0;
  int err_total = 0;
  int total_checks = 0;
  wire [31:0] out_a = {11'h0, pwm_reset, 3'h0, adc_zero_reset, 9'h0, sleep_unit_reset,
    2'h0, watchdog_reset_bit, 3'h0};
  wire [31:0] out_b = {5'h0, analog_cmp_two_reset, analog_cmp_one_reset,
    analog_cmp_zero_reset, 4'h0, gp_counter_three_reset, gp_counter_two_reset,
    gp_counter_one_reset, gp_counter_zero_reset, 1'b0, two_wire_one_reset, 1'b0,
    two_wire_zero_reset, 2'h0, quad_encoder_one_reset, quad_encoder_zero_reset, 2'h0,
    sync_serial_one_reset, sync_serial_zero_reset, 1'b0, async_serial_two_reset,
    async_serial_one_reset, async_serial_zero_reset};

  peripheral_software_reset_ctrl i_dut (.*);

  initial
  forever #20 clock = ~clock;

  // ====================
  // Bus tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    if (a == 12'h040)
      model_a = model_a & ~(capability_mask_a & 32'h0011_0048) | d & capability_mask_a & 32'h0011_0048;
    if (a == 12'h044)
      model_b = model_b & ~(capability_mask_b & 32'h070f_5337) | d & capability_mask_b & 32'h070f_5337;
    @(posedge clock);
    reg_write <= 1'b0;
    #1;
    check(out_a, model_a);
    check(out_b, model_b);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    check(reg_rdata, exp);
  endtask

  task automatic stop_test;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ====================
  // Tests
  initial
  begin
    repeat (4) @(posedge clock);
    sys_rst <= 1'b0;
    rd(12'h040, 32'h0);
    rd(12'h044, 32'h0);
    for (int i = 0; i < 32; i++)
    begin
      wr(12'h040, 32'h1 << i);
      rd(12'h040, model_a);
      wr(12'h044, 32'h1 << i);
      rd(12'h044, model_b);
    end
    wr(12'h040, 32'hffff_ffff);
    wr(12'h044, 32'hffff_ffff);
    rd(12'h040, 32'h0011_0048);
    rd(12'h044, 32'h070f_5337);
    @(posedge clock);
    // Pwm bit masked off, so the clearing write must leave it set
    capability_mask_a <= 32'h0001_0008;
    capability_mask_b <= 32'h0000_0001;
    wr(12'h040, 32'h0);
    wr(12'h044, 32'h0);
    rd(12'h040, 32'h0010_0040);
    rd(12'h044, 32'h070f_5336);
    wr(12'h048, 32'h0);
    rd(12'h048, 32'h0);
    @(posedge clock);
    sys_rst <= 1'b1;
    @(posedge clock);
    sys_rst <= 1'b0;
    #1;
    check(out_a | out_b, 32'h0);
    model_a = 32'h0;
    model_b = 32'h0;
    rd(12'h044, 32'h0);
    stop_test;
  end

  initial
  begin
    #100000;
    err_total++;
    stop_test;
  end
endmodule
`default_nettype wire
